// [design/grr_top.sv]
// Overview of operation
// - Quality record status: space, O or I
// - Quality units: ohm, kilo-ohm or blank
// - Quality number right justified, leading zero kept
// - Quality overflow sends 999999
// - Below one: two zeros; above: two spaces
// - Impedance blank display sends 99999999
// - Impedance status flags under or over range
// - No better range gives range-end status
// - Every record ends in CR then LF
// - Bin record F for bin 00 and bins 09 to 15
// - Bin record carries BIN and number
// - Remote mode locks out manual keys; bias always passes, start only with man_start
// - Listener from own listen address until unlisten
// - Ready data while untalked pulls service request
// - Service request held until talked or polled
// - Serial poll talker sends one status byte
// - Listen code 32+addr, talk 64+addr
// - Decode SPE 24, SPD 25, UNL 63, UNT 95
// - Trigger and local only while listening
// - Data lines negative true, DI08 ignored
// - Status byte bit meanings, remote down to bin
`timescale 1ns/100ps
module grr_top
  import grr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [7:0] dio_n_i,
  output logic [7:0] dio_n_o,
  output logic [7:0] dio_oe_o,
  input wire logic atn_n_i,
  input wire logic dav_n_i,
  output logic dav_n_o,
  output logic dav_oe_o,
  input wire logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_oe_o,
  input wire logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_oe_o,
  output logic srq_n_o,
  output logic srq_oe_o,
  input wire logic meas_done_i,
  input wire logic recal_i,
  input wire logic busy_i,
  input wire logic limits_i,
  input wire logic qd_invalid_i,
  input wire logic qd_ovf_i,
  input wire logic qd_is_d_i,
  input wire logic [1:0] qd_unit_i,
  input wire logic qd_neg_i,
  input wire logic qd_lt_one_i,
  input wire logic [39:0] qd_text_i,
  input wire logic imp_invalid_i,
  input wire logic imp_blank_i,
  input wire logic imp_low_i,
  input wire logic imp_high_i,
  input wire logic imp_lower_rng_i,
  input wire logic imp_higher_rng_i,
  input wire logic [6:0] imp_param_i,
  input wire logic [13:0] imp_unit_i,
  input wire logic imp_neg_i,
  input wire logic [55:0] imp_text_i,
  input wire logic [3:0] bin_num_i,
  input wire logic key_valid_i,
  input wire logic start_key_i,
  input wire logic bias_key_i,
  output logic key_accept_o,
  output logic bias_o,
  output logic meas_start_o,
  output logic [6:0] cmd_byte_o,
  output logic cmd_valid_o,
  output logic remote_o
);

  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] s3;
    logic [11:0] filt;
    logic [4:0] dev_addr;
    logic man_start;
    grr_kind_t kind_sel;
    logic [31:0] rdata;
    logic listen;
    logic talk;
    logic spoll;
    logic remote;
    logic srq;
    logic pend;
    logic trig_pend;
    grr_kind_t kind;
    grr_acc_t acc;
    logic nrfd_oe;
    logic ndac_oe;
    logic [6:0] msg;
    logic msg_vld;
    logic msg_atn;
    grr_src_t src;
    logic [4:0] idx;
    logic [6:0] cnt;
    logic [7:0] dio_oe;
    logic dav_oe;
    logic is_stat;
    logic key_accept;
    logic bias;
    logic meas_start;
    logic [6:0] cmd_byte;
    logic cmd_valid;
  } grr_state_t;

  grr_state_t st;
  grr_state_t nx;
  logic [6:0] fmt_ch;
  logic fmt_last;
  logic atn;
  logic dav;
  logic nrfd_rel;
  logic ndac_rel;
  logic [7:0] rx;
  logic [7:0] stat_byte;

  grr_rec_fmt u_fmt (
    .kind_i(st.kind),
    .idx_i(st.idx),
    .qd_invalid_i(qd_invalid_i),
    .qd_ovf_i(qd_ovf_i),
    .qd_is_d_i(qd_is_d_i),
    .qd_unit_i(qd_unit_i),
    .qd_neg_i(qd_neg_i),
    .qd_lt_one_i(qd_lt_one_i),
    .qd_text_i(qd_text_i),
    .imp_invalid_i(imp_invalid_i),
    .imp_blank_i(imp_blank_i),
    .imp_low_i(imp_low_i),
    .imp_high_i(imp_high_i),
    .imp_lower_rng_i(imp_lower_rng_i),
    .imp_higher_rng_i(imp_higher_rng_i),
    .imp_param_i(imp_param_i),
    .imp_unit_i(imp_unit_i),
    .imp_neg_i(imp_neg_i),
    .imp_text_i(imp_text_i),
    .bin_num_i(bin_num_i),
    .ch_o(fmt_ch),
    .last_o(fmt_last)
  );

  // Filtered bus lines, low level means true
  assign atn = ~st.filt[8];
  assign dav = ~st.filt[9];
  assign nrfd_rel = st.filt[10];
  assign ndac_rel = st.filt[11];
  assign rx = ~st.filt[7:0];

  assign stat_byte = {st.remote, st.srq, recal_i, busy_i, limits_i,
    st.pend && st.kind == K_IMP, st.pend && st.kind == K_QD,
    st.pend && st.kind == K_BIN};

  always_comb
  begin
    nx = st;
    nx.msg_vld = 1'b0;
    nx.cmd_valid = 1'b0;
    nx.meas_start = 1'b0;
    nx.rdata = 32'h0000_0000;

    // Three stages; a line changes only when stages two and three agree
    nx.s1 = {ndac_n_i, nrfd_n_i, dav_n_i, atn_n_i, dio_n_i};
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.filt = (st.s2 & st.s3) | (st.filt & (st.s2 | st.s3));

    if (reg_wr_i && reg_addr_i == ADDR_CTRL)
    begin
      nx.dev_addr = reg_wdata_i[4:0];
      nx.man_start = reg_wdata_i[5];
      nx.kind_sel = grr_kind_t'(reg_wdata_i[7:6]);
    end
    if (reg_rd_i && reg_addr_i == ADDR_CTRL)
      nx.rdata = {24'h00_0000, st.kind_sel, st.man_start, st.dev_addr};
    else if (reg_rd_i && reg_addr_i == ADDR_STAT)
      nx.rdata = {25'h000_0000, st.trig_pend, st.pend, st.spoll, st.srq,
        st.remote, st.talk, st.listen};

    // Acceptor side: joins every handshake under attention or as listener
    case (st.acc)
      A_READY:
      begin
        if (!(atn || st.listen))
        begin
          nx.nrfd_oe = 1'b0;
          nx.ndac_oe = 1'b0;
        end
        else if (dav)
        begin
          nx.msg = rx[6:0];
          nx.msg_vld = 1'b1;
          nx.msg_atn = atn;
          nx.nrfd_oe = 1'b1;
          nx.ndac_oe = 1'b0;
          nx.acc = A_HOLD;
        end
        else
        begin
          nx.nrfd_oe = 1'b0;
          nx.ndac_oe = 1'b1;
        end
      end
      A_HOLD:
      begin
        if (!dav)
        begin
          nx.ndac_oe = 1'b1;
          nx.acc = A_READY;
        end
      end
      default:
        nx.acc = A_READY;
    endcase

    // Interface messages and device-dependent bytes
    if (st.msg_vld && st.msg_atn)
    begin
      if (st.msg == {LA_HI, st.dev_addr})
      begin
        nx.listen = 1'b1;
        nx.remote = 1'b1;
      end
      if (st.msg == CMD_UNL)
        nx.listen = 1'b0;
      if (st.msg == {TA_HI, st.dev_addr})
        nx.talk = 1'b1;
      else if (st.msg[6:5] == TA_HI)
        nx.talk = 1'b0;
      if (st.msg == CMD_SPE)
        nx.spoll = 1'b1;
      if (st.msg == CMD_SPD)
        nx.spoll = 1'b0;
      if (st.msg == CMD_GET && st.listen)
        nx.trig_pend = 1'b1;
      if (st.msg == CMD_GTL && st.listen)
        nx.remote = 1'b0;
    end
    else if (st.msg_vld && st.listen)
    begin
      nx.cmd_byte = st.msg;
      nx.cmd_valid = 1'b1;
    end

    // Trigger waits for unlisten; no measuring while listener
    if (st.trig_pend && !st.listen)
    begin
      nx.trig_pend = 1'b0;
      nx.meas_start = 1'b1;
    end
    if (start_key_i && !st.listen && (!st.remote || st.man_start))
      nx.meas_start = 1'b1;
    nx.key_accept = key_valid_i && !st.remote && !st.listen;
    nx.bias = bias_key_i;

    // Being addressed to talk releases the request; in serial poll it
    // stays up so the status byte still reports it
    if (st.talk && !st.spoll)
      nx.srq = 1'b0;

    // Source side
    case (st.src)
      S_IDLE:
      begin
        nx.dio_oe = 8'h00;
        nx.dav_oe = 1'b0;
        if (meas_done_i)
        begin
          nx.pend = 1'b1;
          nx.kind = st.kind_sel;
          if (!st.talk)
            nx.srq = 1'b1;
        end
        else if (st.talk && !atn && (st.spoll || st.pend))
        begin
          nx.is_stat = st.spoll;
          nx.idx = 5'h00;
          nx.src = S_LOAD;
        end
      end
      S_LOAD:
      begin
        // Open drain: driving low sends a one
        nx.dio_oe = st.is_stat ? stat_byte : {1'b0, fmt_ch};
        nx.cnt = SETTLE_CYC - 7'h01;
        nx.src = S_SETTLE;
      end
      S_SETTLE:
      begin
        if (atn || !st.talk)
        begin
          nx.dio_oe = 8'h00;
          nx.src = S_IDLE;
        end
        else if (st.cnt != 7'h00)
          nx.cnt = st.cnt - 7'h01;
        else if (nrfd_rel && !ndac_rel)
        begin
          nx.dav_oe = 1'b1;
          nx.src = S_DAV;
        end
      end
      S_DAV:
      begin
        // Attention aborts the byte; the record restarts from the top
        if (atn)
        begin
          nx.dav_oe = 1'b0;
          nx.dio_oe = 8'h00;
          nx.src = S_IDLE;
        end
        else if (ndac_rel)
        begin
          nx.dav_oe = 1'b0;
          if (st.is_stat)
          begin
            nx.srq = 1'b0;
            nx.src = S_END;
          end
          else if (fmt_last)
          begin
            nx.pend = 1'b0;
            nx.src = S_END;
          end
          else
          begin
            nx.idx = st.idx + 5'h01;
            nx.src = S_LOAD;
          end
        end
      end
      S_END:
      begin
        nx.dio_oe = 8'h00;
        nx.src = S_IDLE;
      end
      default:
        nx.src = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.s1 <= SYNC_RST;
      st.s2 <= SYNC_RST;
      st.s3 <= SYNC_RST;
      st.filt <= SYNC_RST;
      st.dev_addr <= DEV_ADDR_RST;
      st.man_start <= MAN_START_RST;
    end
    else
      st <= nx;
  end

  assign reg_rdata_o = st.rdata;
  assign dio_oe_o = st.dio_oe;
  assign dav_oe_o = st.dav_oe;
  assign nrfd_oe_o = st.nrfd_oe;
  assign ndac_oe_o = st.ndac_oe;
  assign srq_oe_o = st.srq;
  assign remote_o = st.remote;
  assign key_accept_o = st.key_accept;
  assign bias_o = st.bias;
  assign meas_start_o = st.meas_start;
  assign cmd_byte_o = st.cmd_byte;
  assign cmd_valid_o = st.cmd_valid;
  // Open-drain lines only ever pull low
  assign dio_n_o = 8'h00;
  assign dav_n_o = 1'b0;
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign srq_n_o = 1'b0;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  srq_set_a: assert property (
    meas_done_i && st.src == S_IDLE && !st.talk |=> st.srq)
    else $error("service request not raised for new data");

  srq_hold_a: assert property (
    st.srq && !st.talk && !(st.src == S_DAV && st.is_stat) |=> st.srq)
    else $error("service request dropped too early");

  listen_set_a: assert property (
    st.msg_vld && st.msg_atn && st.msg == {LA_HI, st.dev_addr}
    |=> st.listen && st.remote)
    else $error("own listen address not taken");

  unlisten_a: assert property (
    st.msg_vld && st.msg_atn && st.msg == CMD_UNL |=> !st.listen)
    else $error("unlisten ignored");

  trigger_gate_a: assert property (
    $rose(st.trig_pend) |-> $past(st.listen))
    else $error("trigger taken while not listening");

  trigger_run_a: assert property (
    st.trig_pend && st.listen |=> !st.meas_start)
    else $error("measurement started while listener");

  key_lock_a: assert property (
    key_valid_i && st.remote |=> !st.key_accept)
    else $error("manual key accepted in remote");

  dav_talk_a: assert property (
    $rose(st.dav_oe) |-> $past(st.talk) && $past(st.filt[8]))
    else $error("data valid driven while not talker");

  record_end_a: assert property (
    st.src == S_DAV && !st.is_stat && fmt_last
    |-> st.dio_oe == {1'b0, CH_LF})
    else $error("record does not end in line feed");

  poll_byte_a: assert property (
    st.src == S_SETTLE && st.is_stat |-> st.dio_oe[7] == st.remote)
    else $error("status byte remote bit wrong");

endmodule

// [design/grr_pkg.sv]
package grr_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [4:0] DEV_ADDR_RST = 5'h03;
  localparam logic MAN_START_RST = 1'b0;
  localparam logic [11:0] SYNC_RST = 12'hFFF;

  localparam logic [1:0] LA_HI = 2'h1;
  localparam logic [1:0] TA_HI = 2'h2;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;

  localparam logic [6:0] CH_SP = 7'h20;
  localparam logic [6:0] CH_CR = 7'h0D;
  localparam logic [6:0] CH_LF = 7'h0A;
  localparam logic [6:0] CH_0 = 7'h30;
  localparam logic [6:0] CH_9 = 7'h39;
  localparam logic [6:0] CH_DOT = 7'h2E;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_B = 7'h42;
  localparam logic [6:0] CH_I = 7'h49;
  localparam logic [6:0] CH_N = 7'h4E;
  localparam logic [6:0] CH_F = 7'h46;
  localparam logic [6:0] CH_O = 7'h4F;
  localparam logic [6:0] CH_U = 7'h55;
  localparam logic [6:0] CH_E = 7'h45;
  localparam logic [6:0] CH_Q = 7'h51;
  localparam logic [6:0] CH_D = 7'h44;
  localparam logic [6:0] CH_K = 7'h6B;

  localparam logic [4:0] POS_STATUS = 5'h00;
  localparam logic [4:0] POS_PARAM = 5'h02;
  localparam logic [4:0] POS_UNIT = 5'h04;
  localparam logic [4:0] POS_SIGN = 5'h07;
  localparam logic [4:0] POS_NUM = 5'h08;
  localparam logic [4:0] POS_DOT = 5'h0A;
  localparam logic [4:0] POS_NUM_END = 5'h0E;
  localparam logic [4:0] POS_CR = 5'h0F;
  localparam logic [4:0] REC_LAST = 5'h10;
  localparam logic [4:0] BIN_POS_WORD = 5'h02;
  localparam logic [4:0] BIN_POS_TENS = 5'h06;
  localparam logic [4:0] BIN_POS_UNITS = 5'h07;
  localparam logic [4:0] BIN_POS_CR = 5'h08;
  localparam logic [4:0] BIN_LAST = 5'h09;
  localparam logic [1:0] QD_UNIT_OHM = 2'h1;
  localparam logic [1:0] QD_UNIT_KOHM = 2'h2;

  localparam int CLK_NS = 25;
  localparam int SETTLE_NS = 2000;
  localparam logic [6:0] SETTLE_CYC = 7'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    K_IMP = 2'b00,
    K_QD = 2'b01,
    K_BIN = 2'b10
  } grr_kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LOAD = 3'b001,
    S_SETTLE = 3'b010,
    S_DAV = 3'b011,
    S_END = 3'b100
  } grr_src_t;

  typedef enum logic {
    A_READY = 1'b0,
    A_HOLD = 1'b1
  } grr_acc_t;

endpackage

// [design/grr_rec_fmt.sv]
`timescale 1ns/100ps
module grr_rec_fmt
  import grr_pkg::*;
(
  input wire grr_kind_t kind_i,
  input wire logic [4:0] idx_i,
  input wire logic qd_invalid_i,
  input wire logic qd_ovf_i,
  input wire logic qd_is_d_i,
  input wire logic [1:0] qd_unit_i,
  input wire logic qd_neg_i,
  input wire logic qd_lt_one_i,
  input wire logic [39:0] qd_text_i,
  input wire logic imp_invalid_i,
  input wire logic imp_blank_i,
  input wire logic imp_low_i,
  input wire logic imp_high_i,
  input wire logic imp_lower_rng_i,
  input wire logic imp_higher_rng_i,
  input wire logic [6:0] imp_param_i,
  input wire logic [13:0] imp_unit_i,
  input wire logic imp_neg_i,
  input wire logic [55:0] imp_text_i,
  input wire logic [3:0] bin_num_i,
  output logic [6:0] ch_o,
  output logic last_o
);

  logic [2:0] r;

  always_comb
  begin
    ch_o = CH_SP;
    last_o = 1'b0;
    // Both numeric fields end at the same place, so count from the right
    r = 3'(POS_NUM_END - idx_i);
    case (kind_i)
      K_QD:
      begin
        last_o = (idx_i == REC_LAST);
        if (idx_i == POS_STATUS)
          ch_o = qd_invalid_i ? CH_I : (qd_ovf_i ? CH_O : CH_SP);
        else if (idx_i == POS_PARAM)
          ch_o = qd_is_d_i ? CH_D : CH_Q;
        else if (idx_i == POS_SIGN - 5'h01)
          ch_o = (qd_unit_i != 2'h0) ? CH_O : CH_SP;
        else if (idx_i == POS_SIGN - 5'h02)
          ch_o = (qd_unit_i == QD_UNIT_KOHM) ? CH_K : CH_SP;
        else if (idx_i == POS_SIGN)
          ch_o = qd_neg_i ? CH_MINUS : CH_SP;
        else if (idx_i >= POS_NUM && idx_i <= POS_NUM_END)
        begin
          if (qd_ovf_i)
            ch_o = (idx_i == POS_NUM) ? CH_SP : CH_9;
          else if (idx_i < POS_DOT)
            ch_o = qd_lt_one_i ? CH_0 : CH_SP;
          else if (idx_i == POS_DOT && qd_lt_one_i)
            ch_o = CH_DOT;
          else
            ch_o = qd_text_i[{r, 3'b000} +: 7];
        end
        else if (idx_i == POS_CR)
          ch_o = CH_CR;
        else if (idx_i == REC_LAST)
          ch_o = CH_LF;
      end
      K_BIN:
      begin
        last_o = (idx_i == BIN_LAST);
        if (idx_i == POS_STATUS)
          ch_o = (bin_num_i == 4'h0 || bin_num_i >= 4'h9) ? CH_F : CH_SP;
        else if (idx_i == BIN_POS_WORD)
          ch_o = CH_B;
        else if (idx_i == BIN_POS_WORD + 5'h01)
          ch_o = CH_I;
        else if (idx_i == BIN_POS_WORD + 5'h02)
          ch_o = CH_N;
        else if (idx_i == BIN_POS_TENS)
          ch_o = CH_0;
        else if (idx_i == BIN_POS_UNITS)
          ch_o = CH_0 | {3'h0, bin_num_i};
        else if (idx_i == BIN_POS_CR)
          ch_o = CH_CR;
        else if (idx_i == BIN_LAST)
          ch_o = CH_LF;
      end
      K_IMP:
      begin
        last_o = (idx_i == REC_LAST);
        if (idx_i == POS_STATUS)
        begin
          if (imp_invalid_i)
            ch_o = CH_I;
          else if (imp_low_i)
            ch_o = imp_lower_rng_i ? CH_U : CH_E;
          else if (imp_high_i)
            ch_o = imp_higher_rng_i ? CH_O : CH_E;
        end
        else if (idx_i == POS_PARAM)
          ch_o = imp_param_i;
        else if (idx_i == POS_UNIT)
          ch_o = imp_unit_i[13:7];
        else if (idx_i == POS_UNIT + 5'h01)
          ch_o = imp_unit_i[6:0];
        else if (idx_i >= POS_SIGN && idx_i <= POS_NUM_END && imp_blank_i)
          ch_o = CH_9;
        else if (idx_i == POS_SIGN)
          ch_o = imp_neg_i ? CH_MINUS : CH_SP;
        else if (idx_i >= POS_NUM && idx_i <= POS_NUM_END)
          ch_o = imp_text_i[{r, 3'b000} +: 7];
        else if (idx_i == POS_CR)
          ch_o = CH_CR;
        else if (idx_i == REC_LAST)
          ch_o = CH_LF;
      end
      default:
      begin
        ch_o = CH_SP;
        last_o = 1'b1;
      end
    endcase
  end

endmodule

// [verif/grr_ctl_model.sv]
`timescale 1ns/100ps
module grr_ctl_model
(
  input wire logic clk_i,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic [7:0] dio_n_i,
  output logic atn_oe_o,
  output logic dav_oe_o,
  output logic nrfd_oe_o,
  output logic ndac_oe_o,
  output logic [7:0] dio_oe_o
);
  int timeouts = 0;

  initial
  begin
    {atn_oe_o, dav_oe_o, nrfd_oe_o, ndac_oe_o, dio_oe_o} = '0;
  end

  function automatic logic ok(input int c);
    case (c)
      0: return nrfd_n_i && !ndac_n_i;
      1: return ndac_n_i;
      2: return !dav_n_i;
      default: return dav_n_i;
    endcase
  endfunction

  // Bounded so a stuck handshake is counted instead of hanging the run
  task automatic wt(input int c);
    int n = 0;
    while (!ok(c) && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400)
      timeouts++;
  endtask

  task automatic send(input logic [7:0] b, input logic atn);
    @(posedge clk_i);
    atn_oe_o <= atn;
    ndac_oe_o <= 1'b0;
    nrfd_oe_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wt(0);
    dio_oe_o <= b;
    // Data ahead of the strobe, as the lines share one sync delay
    repeat (2) @(posedge clk_i);
    dav_oe_o <= 1'b1;
    wt(1);
    dav_oe_o <= 1'b0;
    dio_oe_o <= 8'h00;
  endtask

  task automatic recv(output logic [7:0] b);
    @(posedge clk_i);
    atn_oe_o <= 1'b0;
    ndac_oe_o <= 1'b1;
    wt(2);
    b = ~dio_n_i;
    nrfd_oe_o <= 1'b1;
    ndac_oe_o <= 1'b0;
    wt(3);
    ndac_oe_o <= 1'b1;
    nrfd_oe_o <= 1'b0;
  endtask
endmodule

// [verif/gpib_result_reporter_test.sv]
`timescale 1ns/100ps
module gpib_result_reporter_test
  import grr_pkg::*;
;
  logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, c_atn, c_dav, c_nrfd, c_ndac;
  logic [7:0] reg_addr_i, dio_oe_o, c_dio;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic dav_oe_o, nrfd_oe_o, ndac_oe_o, srq_oe_o, meas_done_i, recal_i;
  logic busy_i, limits_i, qd_invalid_i, qd_ovf_i, qd_is_d_i, qd_neg_i;
  logic qd_lt_one_i, imp_invalid_i, imp_blank_i, imp_low_i, imp_high_i;
  logic imp_lower_rng_i, imp_higher_rng_i, imp_neg_i, key_valid_i;
  logic start_key_i, bias_key_i, key_accept_o, bias_o, meas_start_o;
  logic cmd_valid_o, remote_o;
  logic [1:0] qd_unit_i;
  logic [39:0] qd_text_i;
  logic [6:0] imp_param_i, cmd_byte_o;
  logic [13:0] imp_unit_i;
  logic [55:0] imp_text_i;
  logic [3:0] bin_num_i;
  int mismatches = 0;
  int checked = 0;
  int starts = 0;
  // Open-collector bus with pull-ups: low while any party pulls
  wire logic [7:0] dio_n = ~(dio_oe_o | c_dio);
  wire logic dav_n = !(dav_oe_o | c_dav);
  wire logic nrfd_n = !(nrfd_oe_o | c_nrfd);
  wire logic ndac_n = !(ndac_oe_o | c_ndac);

  grr_top u_grr_top
  (
    .ref_clk_i,
    .rst_i,
    .reg_addr_i,
    .reg_wdata_i,
    .reg_wr_i,
    .reg_rd_i,
    .reg_rdata_o,
    .dio_n_i(dio_n),
    .dio_n_o(),
    .dio_oe_o,
    .atn_n_i(!c_atn),
    .dav_n_i(dav_n),
    .dav_n_o(),
    .dav_oe_o,
    .nrfd_n_i(nrfd_n),
    .nrfd_n_o(),
    .nrfd_oe_o,
    .ndac_n_i(ndac_n),
    .ndac_n_o(),
    .ndac_oe_o,
    .srq_n_o(),
    .srq_oe_o,
    .meas_done_i,
    .recal_i,
    .busy_i,
    .limits_i,
    .qd_invalid_i,
    .qd_ovf_i,
    .qd_is_d_i,
    .qd_unit_i,
    .qd_neg_i,
    .qd_lt_one_i,
    .qd_text_i,
    .imp_invalid_i,
    .imp_blank_i,
    .imp_low_i,
    .imp_high_i,
    .imp_lower_rng_i,
    .imp_higher_rng_i,
    .imp_param_i,
    .imp_unit_i,
    .imp_neg_i,
    .imp_text_i,
    .bin_num_i,
    .key_valid_i,
    .start_key_i,
    .bias_key_i,
    .key_accept_o,
    .bias_o,
    .meas_start_o,
    .cmd_byte_o,
    .cmd_valid_o,
    .remote_o
  );

  grr_ctl_model u_ctl
  (
    .clk_i(ref_clk_i),
    .dav_n_i(dav_n),
    .nrfd_n_i(nrfd_n),
    .ndac_n_i(ndac_n),
    .dio_n_i(dio_n),
    .atn_oe_o(c_atn),
    .dav_oe_o(c_dav),
    .nrfd_oe_o(c_nrfd),
    .ndac_oe_o(c_ndac),
    .dio_oe_o(c_dio)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
    if (meas_start_o === 1'b1)
      starts <= starts + 1;

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic key(input logic e);
    @(posedge ref_clk_i);
    {key_valid_i, start_key_i, bias_key_i} <= 3'h7;
    @(posedge ref_clk_i);
    {key_valid_i, start_key_i, bias_key_i} <= 3'h0;
    #1 chk(key_accept_o, e);
    chk(bias_o, 1'b1);
  endtask

  task automatic done(input grr_kind_t k);
    reg_write(ADDR_CTRL, {24'h0, k, 6'h03});
    @(posedge ref_clk_i);
    meas_done_i <= 1'b1;
    @(posedge ref_clk_i);
    meas_done_i <= 1'b0;
    repeat (30) @(posedge ref_clk_i);
    chk(srq_oe_o, 1'b1);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    reg_write(8'h0C, 32'hFFFF_FFFF);
    reg_read(ADDR_CTRL, d);
    chk(d, 32'h0000_0003);
    reg_read(8'h0C, d);
    chk(d, 32'h0);
    reg_read(ADDR_STAT, d);
    chk(d, 32'h0);
  endtask

  task automatic t_addr();
    logic [31:0] d;
    u_ctl.send(CMD_GET, 1'b1);
    repeat (5) @(posedge ref_clk_i);
    chk(starts, 0);
    u_ctl.send(8'hA3, 1'b1);
    reg_read(ADDR_STAT, d);
    chk(d[2:0], 3'h5);
    key(1'b0);
    u_ctl.send(CMD_UNT, 1'b1);
    u_ctl.send(CMD_GET, 1'b1);
    u_ctl.send(CMD_UNL, 1'b1);
    repeat (5) @(posedge ref_clk_i);
    chk(starts, 1);
    reg_read(ADDR_STAT, d);
    chk(d[2:0], 3'h4);
    u_ctl.send(8'h23, 1'b1);
    u_ctl.send(8'hD0, 1'b0);
    #1 chk(cmd_valid_o, 1'b1);
    chk(cmd_byte_o, 7'h50);
    chk(remote_o, 1'b1);
    @(posedge ref_clk_i);
    #1 chk(cmd_valid_o, 1'b0);
    u_ctl.send(CMD_GTL, 1'b1);
    u_ctl.send(CMD_UNL, 1'b1);
    reg_read(ADDR_STAT, d);
    chk(d[2:0], 3'h0);
    chk(remote_o, 1'b0);
    key(1'b1);
    repeat (2) @(posedge ref_clk_i);
    chk(starts, 2);
  endtask

  task automatic t_rec(input grr_kind_t k, input string s);
    logic [7:0] b;
    done(k);
    u_ctl.send(CMD_UNT, 1'b1);
    u_ctl.send(CMD_UNL, 1'b1);
    u_ctl.send(8'h21, 1'b1);
    u_ctl.send(8'h43, 1'b1);
    foreach (s[i])
    begin
      u_ctl.recv(b);
      chk(b[6:0], s[i]);
    end
    #1 chk(srq_oe_o, 1'b0);
    u_ctl.send(CMD_UNT, 1'b1);
  endtask

  task automatic t_imp();
    logic [4:0] f [6] = '{5'h00, 5'h10, 5'h0A, 5'h05, 5'h08, 5'h04};
    string c = " IUOEE";
    string s = "- C uF  1.23456\r\n";
    for (int i = 0; i < 6; i++)
    begin
      {imp_invalid_i, imp_low_i, imp_high_i, imp_lower_rng_i,
        imp_higher_rng_i} <= f[i];
      s[0] = c[i];
      t_rec(K_IMP, s);
    end
    imp_blank_i <= 1'b1;
    t_rec(K_IMP, "E C uF 99999999\r\n");
  endtask

  task automatic t_poll();
    logic [7:0] b;
    u_ctl.send(8'h23, 1'b1);
    u_ctl.send(CMD_UNL, 1'b1);
    reg_write(ADDR_CTRL, 32'h0000_0023);
    key(1'b0);
    repeat (2) @(posedge ref_clk_i);
    chk(starts, 3);
    {recal_i, limits_i} <= 2'h3;
    done(K_BIN);
    u_ctl.send(CMD_SPE, 1'b1);
    u_ctl.send(8'h43, 1'b1);
    u_ctl.recv(b);
    chk(b, 8'hE9);
    u_ctl.send(CMD_UNT, 1'b1);
    u_ctl.send(CMD_SPD, 1'b1);
    chk(srq_oe_o, 1'b0);
  endtask

  initial
  begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, meas_done_i, recal_i,
      busy_i, limits_i, qd_invalid_i, qd_ovf_i, qd_is_d_i, qd_neg_i,
      qd_lt_one_i, qd_unit_i, imp_invalid_i, imp_blank_i, imp_low_i,
      imp_high_i, imp_lower_rng_i, imp_higher_rng_i, imp_neg_i,
      key_valid_i, start_key_i, bias_key_i, bin_num_i} = '0;
    imp_param_i = 7'h43;
    imp_unit_i = {7'h75, 7'h46};
    imp_text_i = "1.23456";
    qd_text_i = "12.34";
    rst_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_addr();
    t_rec(K_BIN, "F BIN 00\r\n");
    bin_num_i <= 4'h8;
    t_rec(K_BIN, "  BIN 08\r\n");
    qd_ovf_i <= 1'b1;
    t_rec(K_QD, "O Q      999999\r\n");
    {qd_ovf_i, qd_invalid_i, qd_unit_i} <= {2'h1, QD_UNIT_OHM};
    t_rec(K_QD, "I Q   O   12.34\r\n");
    {qd_invalid_i, qd_is_d_i, qd_neg_i, qd_lt_one_i} <= 4'h7;
    qd_unit_i <= QD_UNIT_KOHM;
    qd_text_i <= "01234";
    t_rec(K_QD, "  D  kO-00.1234\r\n");
    t_imp();
    t_poll();
    chk(u_ctl.timeouts, 0);
    summarize();
  end

  // Records take about 2000 cycles each; this span is about 45 times that
  initial
  begin
    repeat (90000) @(posedge ref_clk_i);
    mismatches++;
    summarize();
  end
endmodule
